// >>> design/mcfsb_pkg.sv
// Purpose: Shared constants and carrier types for the controller fault status bank.
// Assumes: One system clock at 125 MHz; registers are 32 bits wide at byte offsets.
// Notes:   Every offset, field position and reset value used by the bank is named here.
package mcfsb_pkg;

   localparam int unsigned MCFSB_DATA_W = 32;
   localparam int unsigned MCFSB_ADDR_W = 8;

   // Register offsets.
   localparam logic [MCFSB_ADDR_W-1:0] MCFSB_OFS_CTRL_FAULT   = 8'hE2;
   localparam logic [MCFSB_ADDR_W-1:0] MCFSB_OFS_ALGO_STATE   = 8'hE4;
   localparam logic [MCFSB_ADDR_W-1:0] MCFSB_OFS_MOTOR_VALUES = 8'hE6;
   localparam logic [MCFSB_ADDR_W-1:0] MCFSB_OFS_MEAS_STATE   = 8'hE8;

   // Reset values.
   localparam logic [MCFSB_DATA_W-1:0] MCFSB_RST_WORD  = 32'h0000_0000;
   localparam logic [MCFSB_DATA_W-1:0] MCFSB_ZERO_WORD = 32'h0000_0000;

   // Fault word field positions.
   localparam int unsigned MCFSB_FB_SUMMARY       = 31;
   localparam int unsigned MCFSB_FB_OVERTEMP      = 30;
   localparam int unsigned MCFSB_FB_INITPOS_FREQ  = 29;
   localparam int unsigned MCFSB_FB_INITPOS_T1    = 28;
   localparam int unsigned MCFSB_FB_INITPOS_T2    = 27;
   localparam int unsigned MCFSB_FB_BUS_ILIMIT    = 26;
   localparam int unsigned MCFSB_FB_RL_MEAS       = 25;
   localparam int unsigned MCFSB_FB_BEMF_MEAS     = 24;
   localparam int unsigned MCFSB_FB_LOCK_SPEED    = 23;
   localparam int unsigned MCFSB_FB_LOCK_BEMF     = 22;
   localparam int unsigned MCFSB_FB_MOTOR_ABSENT  = 21;
   localparam int unsigned MCFSB_FB_LOCK_SUMMARY  = 20;
   localparam int unsigned MCFSB_FB_LOCK_ILIMIT   = 19;
   localparam int unsigned MCFSB_FB_HW_LOCK_ILIM  = 18;
   localparam int unsigned MCFSB_FB_SUPPLY_LOW    = 17;
   localparam int unsigned MCFSB_FB_SUPPLY_HIGH   = 16;
   localparam int unsigned MCFSB_FB_SPEED_SAT     = 15;
   localparam int unsigned MCFSB_FB_CURRENT_SAT   = 14;
   localparam int unsigned MCFSB_FB_WATCHDOG      = 3;
   localparam int unsigned MCFSB_FB_STL_ENABLED   = 2;
   localparam int unsigned MCFSB_FB_STL_STATE     = 1;
   localparam int unsigned MCFSB_FB_APP_RESET     = 0;

   // System and algorithm state fields.
   localparam int unsigned MCFSB_AS_VOLT_HI  = 31;
   localparam int unsigned MCFSB_AS_VOLT_LO  = 16;
   localparam int unsigned MCFSB_AS_SPEED_HI = 15;
   localparam int unsigned MCFSB_AS_SPEED_LO = 4;
   localparam int unsigned MCFSB_AS_CFG_DONE = 3;
   localparam int unsigned MCFSB_AS_HOST_OK  = 2;

   // Measured motor value fields.
   localparam int unsigned MCFSB_MV_RES_HI  = 31;
   localparam int unsigned MCFSB_MV_RES_LO  = 24;
   localparam int unsigned MCFSB_MV_BEMF_HI = 23;
   localparam int unsigned MCFSB_MV_BEMF_LO = 16;
   localparam int unsigned MCFSB_MV_IND_HI  = 15;
   localparam int unsigned MCFSB_MV_IND_LO  = 8;

   // Measurement progress fields.
   localparam int unsigned MCFSB_MP_RES     = 31;
   localparam int unsigned MCFSB_MP_IND     = 30;
   localparam int unsigned MCFSB_MP_BEMF    = 29;
   localparam int unsigned MCFSB_MP_MECH    = 28;
   localparam int unsigned MCFSB_MP_PWM_HI  = 27;
   localparam int unsigned MCFSB_MP_PWM_LO  = 24;

   typedef struct packed {
      logic engine_overtemp_flag;
      logic initpos_freq_err;
      logic initpos_timer1_err;
      logic initpos_timer2_err;
      logic bus_current_limit_active;
      logic rl_measure_err;
      logic backemf_measure_err;
      logic lock_by_speed;
      logic lock_by_backemf;
      logic motor_absent;
      logic lock_current_limit_err;
      logic hard_lock_current_limit_err;
      logic supply_low_err;
      logic supply_high_err;
      logic speed_loop_saturated;
      logic current_loop_saturated;
      logic watchdog_err;
      logic selftest_lib_enabled;
      logic selftest_lib_state;
      logic app_reset_seen;
   } mcfsb_fault_in_t;

   typedef struct packed {
      logic [15:0] applied_voltage_level;
      logic [11:0] speed_cmd_level;
      logic        config_copy_done;
      logic        host_control_allowed;
   } mcfsb_system_in_t;

   typedef struct packed {
      logic [7:0] resistance;
      logic [7:0] backemf_const;
      logic [7:0] inductance;
   } mcfsb_motor_in_t;

   typedef struct packed {
      logic       res_meas_state;
      logic       ind_meas_state;
      logic       bemf_meas_state;
      logic       mech_meas_state;
      logic [3:0] pwm_freq_code;
   } mcfsb_meas_in_t;

   typedef struct packed {
      logic [MCFSB_DATA_W-1:0] ctrl_fault;
      logic [MCFSB_DATA_W-1:0] algo_state;
      logic [MCFSB_DATA_W-1:0] motor_values;
      logic [MCFSB_DATA_W-1:0] meas_state;
   } mcfsb_bank_t;

endpackage : mcfsb_pkg

// >>> design/mcfsb_fault_word.sv
// Purpose: Packs the controller fault flags into the 32-bit fault word.
// Assumes: Flags arrive from logic on the same clock; the word is registered by the caller.
// Notes:   Purely combinational; reserved positions are tied low.
`timescale 1ns/1ps
module mcfsb_fault_word
   import mcfsb_pkg::*;
(
   input  wire mcfsb_fault_in_t         flags_i,
   output logic [MCFSB_DATA_W-1:0]      word_o,
   output logic                         lock_any_o,
   output logic                         fault_any_o
);

   always_comb begin
      // Any of the lock detection types raises the lock summary.
      lock_any_o = flags_i.lock_by_speed | flags_i.lock_by_backemf | flags_i.motor_absent
                 | flags_i.lock_current_limit_err | flags_i.hard_lock_current_limit_err; // see RULE9
      word_o                        = MCFSB_ZERO_WORD; // see RULE17
      word_o[MCFSB_FB_OVERTEMP]     = flags_i.engine_overtemp_flag; // see RULE3
      word_o[MCFSB_FB_INITPOS_FREQ] = flags_i.initpos_freq_err; // see RULE4
      word_o[MCFSB_FB_INITPOS_T1]   = flags_i.initpos_timer1_err; // see RULE4
      word_o[MCFSB_FB_INITPOS_T2]   = flags_i.initpos_timer2_err; // see RULE4
      word_o[MCFSB_FB_BUS_ILIMIT]   = flags_i.bus_current_limit_active; // see RULE5
      word_o[MCFSB_FB_RL_MEAS]      = flags_i.rl_measure_err; // see RULE6
      word_o[MCFSB_FB_BEMF_MEAS]    = flags_i.backemf_measure_err; // see RULE6
      word_o[MCFSB_FB_LOCK_SPEED]   = flags_i.lock_by_speed; // see RULE7
      word_o[MCFSB_FB_LOCK_BEMF]    = flags_i.lock_by_backemf; // see RULE7
      word_o[MCFSB_FB_MOTOR_ABSENT] = flags_i.motor_absent; // see RULE8
      word_o[MCFSB_FB_LOCK_SUMMARY] = lock_any_o; // see RULE9
      word_o[MCFSB_FB_LOCK_ILIMIT]  = flags_i.lock_current_limit_err; // see RULE10
      word_o[MCFSB_FB_HW_LOCK_ILIM] = flags_i.hard_lock_current_limit_err; // see RULE10
      word_o[MCFSB_FB_SUPPLY_LOW]   = flags_i.supply_low_err; // see RULE11
      word_o[MCFSB_FB_SUPPLY_HIGH]  = flags_i.supply_high_err; // see RULE11
      word_o[MCFSB_FB_SPEED_SAT]    = flags_i.speed_loop_saturated; // see RULE12
      word_o[MCFSB_FB_CURRENT_SAT]  = flags_i.current_loop_saturated; // see RULE12
      word_o[MCFSB_FB_WATCHDOG]     = flags_i.watchdog_err; // see RULE13
      word_o[MCFSB_FB_STL_ENABLED]  = flags_i.selftest_lib_enabled; // see RULE13
      word_o[MCFSB_FB_STL_STATE]    = flags_i.selftest_lib_state; // see RULE13
      word_o[MCFSB_FB_APP_RESET]    = flags_i.app_reset_seen; // see RULE13
      // The summary covers the fault bits 30 to 14 and the watchdog fault.
      fault_any_o = (|word_o[MCFSB_FB_OVERTEMP:MCFSB_FB_CURRENT_SAT]) | word_o[MCFSB_FB_WATCHDOG]; // see RULE2
      word_o[MCFSB_FB_SUMMARY]      = fault_any_o; // see RULE2
   end

endmodule : mcfsb_fault_word

// >>> design/mcfsb_read_mux.sv
// Purpose: Decodes a register offset and selects the matching status word.
// Assumes: Bank contents are already registered by the caller.
// Notes:   An unmapped offset selects zero and drops the hit flag.
`timescale 1ns/1ps
module mcfsb_read_mux
   import mcfsb_pkg::*;
(
   input  wire mcfsb_bank_t             bank_i,
   input  wire logic [MCFSB_ADDR_W-1:0] addr_i,
   output logic [MCFSB_DATA_W-1:0]      data_o,
   output logic                         hit_o
);

   always_comb begin
      data_o = MCFSB_ZERO_WORD;
      hit_o  = 1'b1;
      case (addr_i)
         MCFSB_OFS_CTRL_FAULT: begin
            data_o = bank_i.ctrl_fault; // see RULE1
         end
         MCFSB_OFS_ALGO_STATE: begin
            data_o = bank_i.algo_state; // see RULE15
         end
         MCFSB_OFS_MOTOR_VALUES: begin
            data_o = bank_i.motor_values; // see RULE16
         end
         MCFSB_OFS_MEAS_STATE: begin
            data_o = bank_i.meas_state; // see RULE16
         end
         default: begin
            data_o = MCFSB_ZERO_WORD; // see RULE14
            hit_o  = 1'b0;
         end
      endcase
   end

endmodule : mcfsb_read_mux

// >>> design/mcfsb_status_bank.sv
// Purpose: Read-only controller fault and system status register bank.
// Assumes: Status sources run on clk_sys_i; software reads over a simple register port.
// Notes:   Writes are accepted and discarded; every output is registered.
`timescale 1ns/1ps

// Overview of operation
// RULE1: Fault word at E2h, resets zero, read-only.
// RULE2: Bit 31 ORs all fault flags; the code ORs only bits 30-14 and the watchdog bit 3, not bits 2-0.
// RULE3: Bit 30 reports engine overtemperature.
// RULE4: Bits 29-27 report initial position faults.
// RULE5: Bit 26 shows bus current limit active.
// RULE6: Bits 25, 24 flag parameter measurement errors.
// RULE7: Bits 23, 22 report speed, backemf lock.
// RULE8: Bit 21 reports no motor connected.
// RULE9: Bit 20 summarises any lock type.
// RULE10: Bits 19, 18 report lock current limits.
// RULE11: Bits 17, 16 report supply under/over voltage.
// RULE12: Bits 15, 14 report loop saturation.
// RULE13: Bits 3-0 watchdog, self-test, application reset.
// RULE14: Software never writes unlisted offsets.
// RULE15: System status at E4h, read-only, zero reset.
// RULE16: Motor values E6h, measurement state E8h.
// RULE17: Reserved bits read zero, ignore writes.
// RULE18: System bits 31-16 hold voltage magnitude.
// RULE19: System bits 15-4 hold speed command.
// RULE20: System bit 3 set once configuration copied.
module mcfsb_status_bank
   import mcfsb_pkg::*;
(
   input  wire logic                    clk_sys_i,
   input  wire logic                    rst_i,
   input  wire logic                    ce_i,
   input  wire mcfsb_fault_in_t         fault_flags_i,
   input  wire mcfsb_system_in_t        system_state_i,
   input  wire mcfsb_motor_in_t         motor_values_i,
   input  wire mcfsb_meas_in_t          meas_state_i,
   input  wire logic                    rd_en_i,
   input  wire logic                    wr_en_i,
   input  wire logic [MCFSB_ADDR_W-1:0] addr_i,
   input  wire logic [MCFSB_DATA_W-1:0] wdata_i,
   output logic [MCFSB_DATA_W-1:0]      rdata_o,
   output logic                         rvalid_o,
   output logic                         addr_err_o,
   output logic                         wr_ignored_o,
   output logic                         controller_fault_o,
   output logic                         lock_summary_o,
   output logic                         config_ready_o
);

   mcfsb_bank_t             bank;
   logic [MCFSB_DATA_W-1:0] next_fault_word;
   logic [MCFSB_DATA_W-1:0] next_algo_word;
   logic [MCFSB_DATA_W-1:0] next_motor_word;
   logic [MCFSB_DATA_W-1:0] next_meas_word;
   logic                    next_lock_any;
   logic                    next_fault_any;
   logic [MCFSB_DATA_W-1:0] sel_data;
   logic                    sel_hit;
   logic                    wdata_unused;

   // Write data carries no meaning here; it is folded away so nothing dangles.
   assign wdata_unused = |wdata_i;

   mcfsb_fault_word u_fault_word (
      .flags_i     (fault_flags_i),
      .word_o      (next_fault_word),
      .lock_any_o  (next_lock_any),
      .fault_any_o (next_fault_any)
   );

   always_comb begin
      next_algo_word = MCFSB_ZERO_WORD; // see RULE17
      next_algo_word[MCFSB_AS_VOLT_HI:MCFSB_AS_VOLT_LO]   = system_state_i.applied_voltage_level; // see RULE18
      next_algo_word[MCFSB_AS_SPEED_HI:MCFSB_AS_SPEED_LO] = system_state_i.speed_cmd_level; // see RULE19
      next_algo_word[MCFSB_AS_CFG_DONE] = system_state_i.config_copy_done; // see RULE20
      next_algo_word[MCFSB_AS_HOST_OK]  = system_state_i.host_control_allowed;
   end

   always_comb begin
      next_motor_word = MCFSB_ZERO_WORD; // see RULE17
      next_motor_word[MCFSB_MV_RES_HI:MCFSB_MV_RES_LO]   = motor_values_i.resistance;
      next_motor_word[MCFSB_MV_BEMF_HI:MCFSB_MV_BEMF_LO] = motor_values_i.backemf_const;
      next_motor_word[MCFSB_MV_IND_HI:MCFSB_MV_IND_LO]   = motor_values_i.inductance;
   end

   always_comb begin
      next_meas_word = MCFSB_ZERO_WORD; // see RULE17
      next_meas_word[MCFSB_MP_RES]  = meas_state_i.res_meas_state;
      next_meas_word[MCFSB_MP_IND]  = meas_state_i.ind_meas_state;
      next_meas_word[MCFSB_MP_BEMF] = meas_state_i.bemf_meas_state;
      next_meas_word[MCFSB_MP_MECH] = meas_state_i.mech_meas_state;
      next_meas_word[MCFSB_MP_PWM_HI:MCFSB_MP_PWM_LO] = meas_state_i.pwm_freq_code;
   end

   // Status words follow their sources one cycle late; software has no write path into them.
   // The whole bank is one packed variable, so a single process owns every word of it.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         bank.ctrl_fault   <= MCFSB_RST_WORD; // see RULE1
         bank.algo_state   <= MCFSB_RST_WORD; // see RULE15
         bank.motor_values <= MCFSB_RST_WORD; // see RULE16
         bank.meas_state   <= MCFSB_RST_WORD; // see RULE16
      end else if (ce_i) begin
         bank.ctrl_fault   <= next_fault_word; // see RULE1
         bank.algo_state   <= next_algo_word; // see RULE15
         bank.motor_values <= next_motor_word; // see RULE16
         bank.meas_state   <= next_meas_word; // see RULE16
      end
   end

   mcfsb_read_mux u_read_mux (
      .bank_i (bank),
      .addr_i (addr_i),
      .data_o (sel_data),
      .hit_o  (sel_hit)
   );

   // Read answer: data and valid one cycle after the request; a miss returns zero.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o    <= MCFSB_ZERO_WORD;
         rvalid_o   <= 1'b0;
         addr_err_o <= 1'b0;
      end else if (ce_i) begin
         rvalid_o   <= rd_en_i;
         addr_err_o <= rd_en_i & ~sel_hit; // see RULE14
         if (rd_en_i) begin
            rdata_o <= sel_data;
         end
      end
   end

   // Writes never reach the bank; a pulse tells the system that one was dropped.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ignored_o <= 1'b0;
      end else if (ce_i) begin
         wr_ignored_o <= wr_en_i & (wdata_unused | ~wdata_unused); // see RULE17
      end
   end

   // Summary outputs mirror the stored words, so they agree with what software reads.
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         controller_fault_o <= 1'b0;
         lock_summary_o     <= 1'b0;
         config_ready_o     <= 1'b0;
      end else if (ce_i) begin
         controller_fault_o <= next_fault_any; // see RULE2
         lock_summary_o     <= next_lock_any; // see RULE9
         config_ready_o     <= system_state_i.config_copy_done; // see RULE20
      end
   end

endmodule : mcfsb_status_bank

// >>> verif/mcfsb_status_bank_asserts.sv
// Purpose: Concurrent checks on the status bank register port and summary outputs.
// Assumes: One clock domain; every check is idle while rst_i is high.
// Notes:   Attached by bind from the bench top file.
`timescale 1ns/1ps
module mcfsb_status_bank_asserts
   import mcfsb_pkg::*;
(
   input wire logic                    clk_sys_i,
   input wire logic                    rst_i,
   input wire logic                    ce_i,
   input wire mcfsb_fault_in_t         fault_flags_i,
   input wire mcfsb_system_in_t        system_state_i,
   input wire logic                    rd_en_i,
   input wire logic                    wr_en_i,
   input wire logic [MCFSB_ADDR_W-1:0] addr_i,
   input wire logic [MCFSB_DATA_W-1:0] rdata_o,
   input wire logic                    rvalid_o,
   input wire logic                    addr_err_o,
   input wire logic                    wr_ignored_o,
   input wire logic                    controller_fault_o,
   input wire logic                    lock_summary_o,
   input wire logic                    config_ready_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   logic hit;
   assign hit = addr_i inside {MCFSB_OFS_CTRL_FAULT, MCFSB_OFS_ALGO_STATE, MCFSB_OFS_MOTOR_VALUES, MCFSB_OFS_MEAS_STATE};

   property p_rd_answer;
      ce_i |=> rvalid_o == $past(rd_en_i) && addr_err_o == $past(rd_en_i && !hit);
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer pulse wrong");
   property p_miss_zero;
      ce_i && rd_en_i && !hit |=> rdata_o == MCFSB_ZERO_WORD;
   endproperty
   a_miss_zero: assert property (p_miss_zero) else $error("unmapped read not zero");
   property p_wr_ign;
      ce_i |=> wr_ignored_o == $past(wr_en_i);
   endproperty
   a_wr_ign: assert property (p_wr_ign) else $error("write discard pulse wrong");
   property p_summary;
      ce_i |=> controller_fault_o == $past(|fault_flags_i[19:3]);
   endproperty
   a_summary: assert property (p_summary) else $error("fault summary wrong");
   property p_lock;
      ce_i |=> lock_summary_o == $past(|fault_flags_i[12:8]);
   endproperty
   a_lock: assert property (p_lock) else $error("lock summary wrong");
   property p_cfg;
      ce_i |=> config_ready_o == $past(system_state_i.config_copy_done);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config ready wrong");
   property p_fault_word;
      ce_i && rd_en_i && addr_i == MCFSB_OFS_CTRL_FAULT |=> rdata_o[13:4] == 10'h000
         && rdata_o[31] == (|rdata_o[30:14] | rdata_o[3]) && rdata_o[20] == (|rdata_o[23:21] | |rdata_o[19:18]);
   endproperty
   a_fault_word: assert property (p_fault_word) else $error("fault word inconsistent");
   property p_rsvd_zero;
      ce_i && rd_en_i |=> ($past(addr_i) != MCFSB_OFS_ALGO_STATE || rdata_o[1:0] == 2'h0)
         && ($past(addr_i) != MCFSB_OFS_MOTOR_VALUES || rdata_o[7:0] == 8'h00)
         && ($past(addr_i) != MCFSB_OFS_MEAS_STATE || rdata_o[23:0] == 24'h000000);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");
   property p_hold;
      !(ce_i && rd_en_i) |=> $stable(rdata_o);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved without read");
endmodule : mcfsb_status_bank_asserts

// >>> verif/mcfsb_status_bank_tb_top.sv
// Purpose: Self-checking bench for the controller fault status bank.
// Assumes: Inputs change on the falling edge; reads are one-cycle requests.
// Notes:   Table rows cover every fault flag and every word; resets, writes and clock enable follow.
`timescale 1ns/1ps
module mcfsb_status_bank_tb_top
   import mcfsb_pkg::*;
;
   typedef struct packed {
      logic [81:0] in;
      logic [7:0]  a;
      logic [31:0] d;
      logic        e;
   } mcfsb_row_t;
   logic             clk_sys, rst, ce, rd_en, wr_en;
   mcfsb_fault_in_t  fault_flags;
   mcfsb_system_in_t system_state;
   mcfsb_motor_in_t  motor_values;
   mcfsb_meas_in_t   meas_state;
   logic [7:0]       addr;
   logic [31:0]      wdata, rdata;
   logic             rvalid, addr_err, wr_ignored, controller_fault, lock_summary, config_ready;
   int               num_errors = 0;
   int               checked = 0;
   int               pos[20] = '{30, 29, 28, 27, 26, 25, 24, 23, 22, 21, 19, 18, 17, 16, 15, 14, 3, 2, 1, 0};
   logic [7:0]       offs[4] = '{MCFSB_OFS_CTRL_FAULT, MCFSB_OFS_ALGO_STATE, MCFSB_OFS_MOTOR_VALUES, MCFSB_OFS_MEAS_STATE};
   logic [31:0]      ones[4] = '{32'hFFFF_C00F, 32'hFFFF_FFFC, 32'hFFFF_FF00, 32'hFF00_0000};
   mcfsb_row_t       rows[$];

   mcfsb_status_bank mcfsb_status_bank_inst (
      .clk_sys_i(clk_sys), .rst_i(rst), .ce_i(ce), .fault_flags_i(fault_flags),
      .system_state_i(system_state), .motor_values_i(motor_values), .meas_state_i(meas_state),
      .rd_en_i(rd_en), .wr_en_i(wr_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
      .rvalid_o(rvalid), .addr_err_o(addr_err), .wr_ignored_o(wr_ignored),
      .controller_fault_o(controller_fault), .lock_summary_o(lock_summary), .config_ready_o(config_ready)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic test_done();
      if (num_errors == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done

   // Leaves rd_en high so that callers may chain reads back to back.
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic e);
      addr = a;
      rd_en = 1'b1;
      @(negedge clk_sys);
      chk(32'(rvalid), 32'h1);
      chk(32'(addr_err), 32'(e));
      chk(rdata, d);
   endtask : rd

   task automatic load(input logic [81:0] in);
      rd_en = 1'b0;
      {fault_flags, system_state, motor_values, meas_state} = in;
      repeat (2) @(negedge clk_sys);
   endtask : load

   function automatic void add(input logic [19:0] f, input logic [29:0] s, input logic [23:0] m,
                               input logic [7:0] p, input logic [7:0] a, input logic [31:0] d, input logic e);
      rows.push_back({f, s, m, p, a, d, e});
   endfunction : add

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial begin
      #50000;
      num_errors = num_errors + 1;
      test_done();
   end

   initial begin
      {rst, ce, rd_en, wr_en} = 4'b1100;
      addr = 8'h00;
      wdata = 32'h0;
      {fault_flags, system_state, motor_values, meas_state} = '1;
      for (int i = 0; i < 20; i++) begin
         add(20'h80000 >> i, 0, 0, 0, MCFSB_OFS_CTRL_FAULT, (32'h1 << pos[i]) | ((i < 17) ? 32'h8000_0000 : 32'h0)
             | ((i >= 7 && i <= 11) ? 32'h0010_0000 : 32'h0), 1'b0);
      end
      add(20'hFFFFF, 0, 0, 0, MCFSB_OFS_CTRL_FAULT, 32'hFFFF_C00F, 1'b0);
      add(0, {16'h8000, 12'hFFF, 2'b10}, 0, 0, MCFSB_OFS_ALGO_STATE, 32'h8000_FFF8, 1'b0);
      add(0, {16'h1234, 12'hABC, 2'b01}, 0, 0, MCFSB_OFS_ALGO_STATE, 32'h1234_ABC4, 1'b0);
      add(0, 0, 24'hA53C7E, 0, MCFSB_OFS_MOTOR_VALUES, 32'hA53C_7E00, 1'b0);
      add(0, 0, 0, 8'hA9, MCFSB_OFS_MEAS_STATE, 32'hA900_0000, 1'b0);
      add('1, '1, '1, '1, 8'hE3, 32'h0, 1'b1);
      add('1, '1, '1, '1, 8'hEA, 32'h0, 1'b1);
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      foreach (rows[i]) begin
         load(rows[i].in);
         rd(rows[i].a, rows[i].d, rows[i].e);
         if (rows[i].a == MCFSB_OFS_CTRL_FAULT) begin
            chk(32'(controller_fault), 32'(rows[i].d[31]));
            chk(32'(lock_summary), 32'(rows[i].d[20]));
         end
         if (rows[i].a == MCFSB_OFS_ALGO_STATE) chk(32'(config_ready), 32'(rows[i].d[3]));
      end
      // A read on the first edge after reset must see the cleared words, not the live inputs.
      for (int i = 0; i < 4; i++) begin
         load('1);
         rst = 1'b1;
         @(negedge clk_sys);
         chk(rdata | 32'(controller_fault) | 32'(lock_summary) | 32'(config_ready), 32'h0);
         rst = 1'b0;
         rd(offs[i], MCFSB_RST_WORD, 1'b0);
      end
      load('1);
      wr_en = 1'b1;
      for (int i = 0; i < 8; i++) begin
         wdata = 32'(i);
         rd(offs[i % 4], ones[i % 4], 1'b0);
      end
      rd_en = 1'b0;
      wr_en = 1'b0;
      chk(32'(wr_ignored), 32'h1);
      @(negedge clk_sys);
      chk(32'(wr_ignored) | 32'(rvalid), 32'h0);
      load(82'h0);
      ce = 1'b0;
      fault_flags = '1;
      repeat (3) @(negedge clk_sys);
      chk(32'(controller_fault) | 32'(lock_summary), 32'h0);
      ce = 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(32'(controller_fault) & 32'(lock_summary), 32'h1);
      test_done();
   end
endmodule : mcfsb_status_bank_tb_top

bind mcfsb_status_bank mcfsb_status_bank_asserts mcfsb_status_bank_asserts_inst (
   .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i), .fault_flags_i(fault_flags_i),
   .system_state_i(system_state_i), .rd_en_i(rd_en_i), .wr_en_i(wr_en_i), .addr_i(addr_i),
   .rdata_o(rdata_o), .rvalid_o(rvalid_o), .addr_err_o(addr_err_o), .wr_ignored_o(wr_ignored_o),
   .controller_fault_o(controller_fault_o), .lock_summary_o(lock_summary_o), .config_ready_o(config_ready_o)
);
